// >>> hw/motion_state_priority_encoder.v
// Notes on behaviour
// [R1] leaving sleep reinitialises every state and flag like power-on reset
// [R2] after power-on reset the machine sits in standby
// [R3] two-stage motion uses own parameter set, unspecified values copied at start
// [R4] second motion of two-stage forces accel shape to 1
// [R5] parameter register reads return working values, never two-stage copies
// [R6] sleep flag set by timeout or sleep command, cleared by next command
// [R7] shutdown state held until thermal and hardware-stop flags are clear
// [R8] fault flags clear only at a status read with conditions normal
// [R9] master avoids changing accel or vmin during a normal motion
// [R10] sleep while moving goes via ramped halt, or a move to secure position if enabled, then stopped, not directly
// [R11] stopped with sleep: sleep if no secure, at secure, or stop; else move there
// [R12] secure enable is 1 whenever secure position differs from 0x400
// [R13] stop flag set leaving halts, cleared first edge in stopped
// [R14] identifier assignment decoded in all states but sleep, state unchanged
// [R15] stopped with position mismatch moves to target at lowest priority
// [R16] step loss does not block position commands; cleared only by status read
// [R17] with sleep allow 0 stopped never goes to sleep
// [R18] long undervoltage halts: stopped/moving/ramped to undervolt halt, two-stage abrupt
// [R19] undervolt bridges-off returns to stopped once undervoltage is not long
// [R20] entering shutdown puts bridges in hi-z and copies actual into target
// [R21] shutdown exit needs a status read and all causes gone
// [R22] state updates once per clock, highest priority transition wins
`include "motion_state_defines.vh"
`default_nettype none

module motion_state_priority_encoder #(
  parameter [31:0] UV_HOLD_CYCLES = `UV_HOLD_TIME_S * `CLK_FREQ_HZ
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  input  wire        clk_en,
  // register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // decoded bus commands, one-cycle pulses
  input  wire        cmd_valid,
  input  wire        position_cmd,
  input  wire        short_position_cmd,
  input  wire        secure_move_cmd,
  input  wire        two_stage_cmd,
  input  wire        ramped_halt_cmd,
  input  wire        abrupt_halt_cmd,
  input  wire        sleep_cmd,
  input  wire        bus_timeout,
  input  wire        status_read_cmd,
  input  wire        full_status_read_cmd,
  input  wire        dyn_id_cmd,
  input  wire        wake,
  // command data
  input  wire [15:0] cmd_position,
  input  wire [15:0] cmd_position2,
  input  wire [3:0]  cmd_vmax,
  input  wire        cmd_vmax_given,
  input  wire [3:0]  cmd_vmin,
  input  wire        cmd_vmin_given,
  // motion engine
  input  wire [15:0] act_pos,
  input  wire        motion_done,
  // fault pins, asynchronous
  input  wire        thermal_pin,
  input  wire        undervolt_pin,
  input  wire        elec_defect_pin,
  // state and drive outputs
  output reg  [3:0]  motion_state,
  output reg  [15:0] target_pos,
  output reg         bridges_hiz,
  output reg         hold_current,
  output reg         accel_shape,
  output reg  [3:0]  vmax_eff,
  output reg  [3:0]  vmin_eff,
  output reg         id_assign,
  // flags
  output reg         secure_enable,
  output reg         sleep_flag,
  output reg         stop_flag,
  output reg         step_loss_flag,
  output reg         tsd_flag,
  output reg         uv2_flag,
  output reg         eldef_flag,
  output reg         hw_stop_flag
);

  localparam [3:0] ST_STANDBY    = 4'h0;
  localparam [3:0] ST_STOPPED    = 4'h1;
  localparam [3:0] ST_MOVING     = 4'h2;
  localparam [3:0] ST_TWO_STAGE  = 4'h3;
  localparam [3:0] ST_RAMPED     = 4'h4;
  localparam [3:0] ST_ABRUPT     = 4'h5;
  localparam [3:0] ST_RAMPED_DONE = 4'h6;
  localparam [3:0] ST_SHUTDOWN   = 4'h7;
  localparam [3:0] ST_SLEEP      = 4'h8;
  localparam [3:0] ST_UV_HALT    = 4'h9;
  localparam [3:0] ST_UV_OFF     = 4'hA;

  // pin synchronisers: sy1 feeds sy2 only
  reg  [2:0]  sy1_q;
  reg  [2:0]  sy2_q;
  reg  [2:0]  sy3_q;
  reg  [2:0]  pin_q;
  reg  [31:0] uv_cnt_q;
  // bus-owned state
  reg         sleep_allow_q;
  reg         work_acc_q;
  reg  [3:0]  work_vmax_q;
  reg  [3:0]  work_vmin_q;
  reg  [10:0] secpos_q;
  // two-stage private set
  reg         dual_acc_q;
  reg  [3:0]  dual_vmax_q;
  reg  [3:0]  dual_vmin_q;
  reg  [15:0] dual_pos2_q;
  reg         stage_q;
  reg         status_seen_q;
  // next-state terms
  reg  [3:0]  state_d;
  reg  [15:0] tag_d;
  reg         stage_d;
  reg         dual_load;
  reg         step_set;
  reg  [31:0] rd_mux;

  wire        tsd_s      = pin_q[0];
  wire        uv_s       = pin_q[1];
  wire        eldef_s    = pin_q[2];
  wire        uv_long    = (uv_cnt_q == UV_HOLD_CYCLES);
  wire        status_rd  = status_read_cmd | full_status_read_cmd;
  wire        pos_cmd    = position_cmd | short_position_cmd;
  wire        sleep_req  = sleep_cmd | bus_timeout;
  wire [15:0] sec_full   = {secpos_q, 5'h00};
  wire        at_secure  = (act_pos == sec_full);
  wire        reinit     = (motion_state == ST_SLEEP) & wake;
  wire [3:0]  load_vmax  = cmd_vmax_given ? cmd_vmax : work_vmax_q;
  wire [3:0]  load_vmin  = cmd_vmin_given ? cmd_vmin : work_vmin_q;
  wire        leave_halt = ((motion_state == ST_RAMPED) | (motion_state == ST_ABRUPT)) &
                           (state_d != motion_state);

  always @* begin
    state_d   = motion_state;
    tag_d     = target_pos;
    stage_d   = stage_q;
    dual_load = 1'b0;
    step_set  = 1'b0;
    // one priority chain per state, first match wins [R22]
    case (motion_state)
      ST_STANDBY: begin
        if (cmd_valid)
          state_d = ST_STOPPED;
      end
      ST_STOPPED: begin
        if (tsd_flag | eldef_flag) begin
          state_d = ST_SHUTDOWN;
        end else if (uv_long) begin
          state_d = ST_UV_HALT; // [R18]
        end else if (sleep_flag & sleep_allow_q) begin // [R17]
          if (!secure_enable | at_secure | stop_flag) begin // [R11]
            state_d = ST_SLEEP;
          end else begin
            tag_d   = sec_full; // [R11]
            state_d = ST_MOVING;
          end
        end else if (two_stage_cmd) begin
          dual_load = 1'b1; // [R3]
          stage_d   = 1'b0;
          tag_d     = cmd_position;
          state_d   = ST_TWO_STAGE;
        end else if (pos_cmd) begin
          tag_d   = cmd_position; // [R16]
          state_d = ST_MOVING;
        end else if (secure_move_cmd & secure_enable) begin
          tag_d   = sec_full; // [R16]
          state_d = ST_MOVING;
        end else if (act_pos != target_pos) begin
          state_d = ST_MOVING; // [R15]
        end
      end
      ST_MOVING: begin
        if (tsd_flag) begin
          state_d = ST_RAMPED;
        end else if (eldef_flag) begin
          state_d  = ST_ABRUPT;
          step_set = 1'b1;
        end else if (uv_long) begin
          state_d = ST_UV_HALT; // [R18]
        end else if (abrupt_halt_cmd) begin
          state_d = ST_ABRUPT;
        end else if (ramped_halt_cmd) begin
          state_d = ST_RAMPED;
        end else if (sleep_req) begin
          // no direct jump to sleep; the flag is judged again once stopped
          if (secure_enable)
            tag_d = sec_full;
          else
            state_d = ST_RAMPED; // [R10]
        end else if (motion_done) begin
          state_d = ST_STOPPED;
        end else if (pos_cmd) begin
          tag_d = cmd_position; // [R16]
        end else if (secure_move_cmd & secure_enable) begin
          tag_d = sec_full; // [R16]
        end
      end
      ST_TWO_STAGE: begin
        if (tsd_flag) begin
          state_d = ST_RAMPED;
        end else if (eldef_flag) begin
          state_d  = ST_ABRUPT;
          step_set = 1'b1;
        end else if (uv_long | abrupt_halt_cmd) begin
          state_d = ST_ABRUPT; // [R18]
        end else if (motion_done) begin
          if (!stage_q) begin
            stage_d = 1'b1;
            tag_d   = dual_pos2_q;
          end else begin
            state_d = ST_STOPPED;
          end
        end
      end
      ST_RAMPED: begin
        if (eldef_flag) begin
          state_d  = ST_ABRUPT;
          step_set = 1'b1;
        end else if (uv_long) begin
          state_d = ST_UV_HALT; // [R18]
        end else if (abrupt_halt_cmd) begin
          state_d = ST_ABRUPT;
        end else if (motion_done) begin
          tag_d   = act_pos;
          state_d = tsd_flag ? ST_RAMPED_DONE : ST_STOPPED; // [R10]
        end
      end
      ST_ABRUPT: begin
        if (motion_done) begin
          tag_d   = act_pos;
          state_d = ST_STOPPED;
        end
      end
      ST_RAMPED_DONE: begin
        if (tsd_flag | eldef_flag)
          state_d = ST_SHUTDOWN;
        else
          state_d = ST_STOPPED;
      end
      ST_SHUTDOWN: begin
        // lost bus while shut down sleeps at once
        if (sleep_flag)
          state_d = ST_SLEEP;
        else if (status_seen_q & !tsd_flag & !hw_stop_flag & !tsd_s & !uv_long & !eldef_s)
          state_d = ST_STOPPED; // [R7] [R21]
      end
      ST_UV_HALT: begin
        if (motion_done)
          state_d = ST_UV_OFF;
      end
      ST_UV_OFF: begin
        if (tsd_flag | eldef_flag)
          state_d = ST_SHUTDOWN;
        else if (!uv_long)
          state_d = ST_STOPPED; // [R19]
      end
      ST_SLEEP: state_d = ST_SLEEP;
      default: begin
        state_d = ST_STANDBY;
      end
    endcase
    if (state_d == ST_SHUTDOWN)
      tag_d = act_pos; // [R20]
  end

  always @* begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      `REG_CTRL_OFS:   rd_mux = {30'h0000_0000, work_acc_q, sleep_allow_q};
      `REG_PARAM_OFS:  rd_mux = {24'h00_0000, work_vmin_q, work_vmax_q}; // [R5]
      `REG_SECPOS_OFS: rd_mux = {21'h00_0000, secpos_q};
      `REG_TARGET_OFS: rd_mux = {16'h0000, target_pos};
      `REG_ACTPOS_OFS: rd_mux = {16'h0000, act_pos};
      `REG_STATUS_OFS: rd_mux = {19'h0_0000, bridges_hiz, secure_enable, hw_stop_flag,
                                 eldef_flag, uv2_flag, tsd_flag, step_loss_flag,
                                 stop_flag, sleep_flag, motion_state};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // hardware-facing inputs, not touched by reinit
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sy1_q    <= 3'h0;
      sy2_q    <= 3'h0;
      sy3_q    <= 3'h0;
      pin_q    <= 3'h0;
      uv_cnt_q <= 32'h0000_0000;
    end else if (clk_en) begin
      sy1_q <= {elec_defect_pin, undervolt_pin, thermal_pin};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      // a change counts once two later stages agree, filtering a metastable sample
      pin_q <= (sy2_q & ~(sy2_q ^ sy3_q)) | (pin_q & (sy2_q ^ sy3_q));
      if (!uv_s)
        uv_cnt_q <= 32'h0000_0000;
      else if (!uv_long)
        uv_cnt_q <= uv_cnt_q + 32'h0000_0001;
    end
  end

  // one list serves power-on reset and wake from sleep, so the two cannot drift apart
  task init_all; begin
    motion_state   <= ST_STANDBY;
    target_pos     <= `POS_RESET;
    stage_q        <= 1'b0;
    dual_acc_q     <= 1'b0;
    dual_vmax_q    <= `VMAX_RESET;
    dual_vmin_q    <= `VMIN_RESET;
    dual_pos2_q    <= `POS_RESET;
    status_seen_q  <= 1'b0;
    sleep_allow_q  <= 1'b0;
    work_acc_q     <= 1'b0;
    work_vmax_q    <= `VMAX_RESET;
    work_vmin_q    <= `VMIN_RESET;
    secpos_q       <= `SECPOS_RESET;
    secure_enable  <= 1'b0;
    sleep_flag     <= 1'b0;
    stop_flag      <= 1'b0;
    step_loss_flag <= 1'b0;
    tsd_flag       <= 1'b0;
    uv2_flag       <= 1'b0;
    eldef_flag     <= 1'b0;
    hw_stop_flag   <= 1'b0;
    reg_rdata      <= 32'h0000_0000;
    bridges_hiz    <= 1'b0;
    hold_current   <= 1'b0;
    accel_shape    <= 1'b0;
    vmax_eff       <= `VMAX_RESET;
    vmin_eff       <= `VMIN_RESET;
    id_assign      <= 1'b0;
  end
  endtask

  always @(posedge clk or posedge reset) begin
    if (reset)
      init_all; // [R2]
    else if (clk_en) begin
      if (reinit)
        init_all; // [R1]
      else begin
        motion_state <= state_d; // [R22]
        target_pos   <= tag_d;
        stage_q      <= stage_d;
        reg_rdata    <= reg_rd ? rd_mux : 32'h0000_0000;
        if (reg_wr && reg_addr == `REG_CTRL_OFS) begin
          sleep_allow_q <= reg_wdata[`CTRL_SLEEP_ALLOW_BIT];
          work_acc_q    <= reg_wdata[`CTRL_ACCEL_SHAPE_BIT];
        end
        // a vmin change mid-motion is the master's to avoid [R9]
        if (reg_wr && reg_addr == `REG_PARAM_OFS) begin
          work_vmax_q <= reg_wdata[`PARAM_VMAX_LSB +: 4];
          work_vmin_q <= reg_wdata[`PARAM_VMIN_LSB +: 4];
        end
        if (reg_wr && reg_addr == `REG_SECPOS_OFS) begin
          secpos_q      <= reg_wdata[10:0];
          secure_enable <= (reg_wdata[10:0] != `SECPOS_DISABLED); // [R12]
        end
        if (dual_load) begin
          dual_acc_q  <= work_acc_q; // [R3]
          dual_vmax_q <= load_vmax;
          dual_vmin_q <= load_vmin;
          dual_pos2_q <= cmd_position2;
        end
        // the private set drives the motor only inside the sequence
        if (state_d == ST_TWO_STAGE) begin
          // the private set is still loading on the entry edge
          accel_shape <= stage_d ? 1'b1 : (dual_load ? work_acc_q : dual_acc_q); // [R4]
          vmax_eff    <= dual_load ? load_vmax : dual_vmax_q;
          vmin_eff    <= dual_load ? load_vmin : dual_vmin_q;
        end else begin
          accel_shape <= work_acc_q;
          vmax_eff    <= work_vmax_q;
          vmin_eff    <= work_vmin_q;
        end
        sleep_flag     <= sleep_req | (sleep_flag & ~cmd_valid); // [R6]
        stop_flag      <= leave_halt | (stop_flag & (motion_state != ST_STOPPED)); // [R13]
        step_loss_flag <= step_set | (step_loss_flag & ~status_rd); // [R16]
        // a present cause always wins over the clearing read [R8]
        tsd_flag       <= tsd_s | (tsd_flag & ~status_rd);
        uv2_flag       <= uv_long | (uv2_flag & ~status_rd);
        eldef_flag     <= eldef_s | (eldef_flag & ~status_rd);
        hw_stop_flag   <= eldef_s | (hw_stop_flag & ~status_rd);
        status_seen_q  <= (motion_state == ST_SHUTDOWN) & (status_seen_q | status_rd); // [R21]
        bridges_hiz  <= (state_d == ST_SHUTDOWN) | (state_d == ST_UV_OFF) |
                        (state_d == ST_SLEEP); // [R20]
        hold_current <= (state_d == ST_STOPPED);
        id_assign    <= dyn_id_cmd & (motion_state != ST_SLEEP); // [R14]
      end
    end
  end

endmodule

`default_nettype wire

// >>> hw/motion_state_defines.vh
`ifndef MOTION_STATE_DEFINES_VH
`define MOTION_STATE_DEFINES_VH

// register byte offsets
`define REG_CTRL_OFS        8'h00
`define REG_PARAM_OFS       8'h04
`define REG_SECPOS_OFS      8'h08
`define REG_TARGET_OFS      8'h0C
`define REG_STATUS_OFS      8'h10
`define REG_ACTPOS_OFS      8'h14

// control register fields
`define CTRL_SLEEP_ALLOW_BIT 0
`define CTRL_ACCEL_SHAPE_BIT 1

// parameter register fields
`define PARAM_VMAX_LSB      0
`define PARAM_VMIN_LSB      4

// status register fields
`define STAT_STATE_LSB      0
`define STAT_SLEEP_BIT      4
`define STAT_STOP_BIT       5
`define STAT_STEPLOSS_BIT   6
`define STAT_TSD_BIT        7
`define STAT_UV2_BIT        8
`define STAT_ELDEF_BIT      9
`define STAT_HWSTOP_BIT     10
`define STAT_SECURE_ENABLE_BIT      11
`define STAT_HIZ_BIT        12

// reset values
`define CTRL_RESET          2'h0
`define VMAX_RESET          4'h0
`define VMIN_RESET          4'h0
`define SECPOS_RESET        11'h400
`define SECPOS_DISABLED     11'h400
`define POS_RESET           16'h0000

// timing
`define CLK_FREQ_HZ         125000000
`define UV_HOLD_TIME_S      15

`endif

// >>> test/motion_state_monitor.sv
`default_nettype none
module motion_state_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        clk_en,
  // register writes and commands
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        cmd_valid,
  input wire logic        sleep_cmd,
  input wire logic        bus_timeout,
  input wire logic        status_read_cmd,
  input wire logic        full_status_read_cmd,
  input wire logic        dyn_id_cmd,
  input wire logic        wake,
  input wire logic [15:0] act_pos,
  input wire logic        motion_done,
  // state and flags
  input wire logic [3:0]  motion_state,
  input wire logic [15:0] target_pos,
  input wire logic        bridges_hiz,
  input wire logic        hold_current,
  input wire logic        accel_shape,
  input wire logic        id_assign,
  input wire logic        secure_enable,
  input wire logic        sleep_flag,
  input wire logic        stop_flag,
  input wire logic        step_loss_flag,
  input wire logic        tsd_flag,
  input wire logic        uv2_flag,
  input wire logic        eldef_flag,
  input wire logic        hw_stop_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] secpos_q;
  logic        allow_q;
  logic        quiet;
  // frozen cycles abort pending checks rather than stretch them
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !clk_en);
  assign quiet = !cmd_valid && !bus_timeout && !tsd_flag && !hw_stop_flag && !uv2_flag
    && !eldef_flag;
  // shadow of secure position and sleep allow, reinitialised by wake from sleep
  always_ff @(posedge clk or posedge reset) begin
    if (reset || (clk_en && wake && motion_state == 4'h8)) begin
      secpos_q <= 11'h400;
      allow_q  <= 1'b0;
    end else if (clk_en && reg_wr && reg_addr == 8'h08) begin
      secpos_q <= reg_wdata[10:0];
    end else if (clk_en && reg_wr && reg_addr == 8'h00) begin
      allow_q <= reg_wdata[0];
    end
  end
  sequence s_halt_exit;
    (motion_state inside {4'h4, 4'h5}) ##1 !(motion_state inside {4'h4, 4'h5});
  endsequence
  sequence s_shut_exit;
    motion_state == 4'h7 ##1 !(motion_state inside {4'h7, 4'h8});
  endsequence
  a_reset_standby: assert property ($fell(reset) |-> motion_state == 4'h0)
    else $error("not standby after reset");
  a_stop_set: assert property (s_halt_exit |-> stop_flag)
    else $error("stop flag not set leaving halt");
  a_stop_clear: assert property (motion_state == 4'h1 |=> !stop_flag)
    else $error("stop flag not cleared in stopped");
  a_secure_code: assert property ($stable(secpos_q) |-> secure_enable == (secpos_q != 11'h400))
    else $error("secure enable wrong");
  a_sleep_flag: assert property ((cmd_valid || bus_timeout) && motion_state != 4'h8
    |=> sleep_flag == $past(sleep_cmd || bus_timeout)) else $error("sleep flag wrong");
  a_no_allow: assert property (motion_state == 4'h1 && !allow_q |=> motion_state != 4'h8)
    else $error("sleep entered while not allowed");
  a_via_halt: assert property (motion_state == 4'h2 |=> motion_state != 4'h8)
    else $error("direct jump from moving to sleep");
  a_sleep_enter: assert property (motion_state == 4'h1 && sleep_flag && allow_q
    && !secure_enable && quiet |=> motion_state == 4'h8) else $error("sleep not entered");
  a_lowprio_move: assert property (motion_state == 4'h1 && target_pos != act_pos
    && !sleep_flag && !stop_flag && quiet |=> motion_state == 4'h2) else $error("no move");
  a_dyn_id: assert property (dyn_id_cmd |=> id_assign == ($past(motion_state) != 4'h8))
    else $error("id assignment wrong");
  a_steploss_hold: assert property (step_loss_flag && !status_read_cmd
    && !full_status_read_cmd && motion_state != 4'h8 |=> step_loss_flag)
    else $error("step loss lost without read");
  a_shut_hiz: assert property (motion_state == 4'h7 ##1 motion_state == 4'h7
    |-> bridges_hiz && target_pos == $past(act_pos)) else $error("shutdown drive wrong");
  a_shut_exit: assert property (s_shut_exit |-> motion_state == 4'h1 && hold_current
    && !tsd_flag && !hw_stop_flag) else $error("shutdown left too early");
  a_second_shape: assert property (motion_state == 4'h3 && motion_done ##1
    motion_state == 4'h3 |-> accel_shape) else $error("shape not forced");
endmodule
bind motion_state_priority_encoder motion_state_monitor mon_u (.*);
`default_nettype wire

// >>> test/lin_master_model.sv
`default_nettype none
module lin_master_model (
  // clock
  input  wire logic        clk,
  // decoded frames
  output var  logic [11:0] stb,
  output var  logic        cmd_valid,
  output var  logic [15:0] pos,
  output var  logic [15:0] pos2,
  output var  logic [9:0]  prm
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    stb       = 12'h000;
    cmd_valid = 1'b0;
    pos       = 16'h0000;
    pos2      = 16'h0000;
    prm       = 10'h000;
  end
  // one frame per call; no parameter frames are sent while moving
  task automatic send(input int k, input logic [15:0] p, input logic [15:0] p2,
                      input logic [9:0] q);
    @(posedge clk);
    stb       <= 12'h001 << k;
    cmd_valid <= k != 7 && k != 11;
    pos       <= p;
    pos2      <= p2;
    prm       <= q;
    @(posedge clk);
    stb       <= 12'h000;
    cmd_valid <= 1'b0;
    // released data does not keep its last value
    pos       <= ~p;
    pos2      <= ~p2;
    prm       <= ~q;
  endtask
endmodule
`default_nettype wire

// >>> test/motion_state_priority_encoder_tb.sv
`default_nettype none
module motion_state_priority_encoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, motion_done = 0;
  logic        thermal_pin = 0, undervolt_pin = 0, elec_defect_pin = 0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [15:0] act_pos = 16'h0000;
  wire  [31:0] reg_rdata;
  wire  [15:0] pos, pos2, target_pos;
  wire  [11:0] stb;
  wire  [9:0]  prm;
  wire  [3:0]  motion_state, vmax_eff, vmin_eff;
  wire         cmd_valid, bridges_hiz, hold_current, accel_shape, id_assign, secure_enable;
  wire         sleep_flag, stop_flag, step_loss_flag, tsd_flag, uv2_flag, eldef_flag, hw_stop_flag;
  int          bad_count = 0, n_tests = 0;
  always #4 clk = ~clk;
  lin_master_model m_u (.clk, .stb, .cmd_valid, .pos, .pos2, .prm);
  // long undervoltage shortened to 20 cycles
  motion_state_priority_encoder #(.UV_HOLD_CYCLES(32'd20)) dut_u (.clk, .reset, .clk_en,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_valid, .position_cmd(stb[0]),
    .short_position_cmd(stb[1]), .secure_move_cmd(stb[2]), .two_stage_cmd(stb[3]),
    .ramped_halt_cmd(stb[4]), .abrupt_halt_cmd(stb[5]), .sleep_cmd(stb[6]),
    .bus_timeout(stb[7]), .status_read_cmd(stb[8]), .full_status_read_cmd(stb[9]),
    .dyn_id_cmd(stb[10]), .wake(stb[11]), .cmd_position(pos), .cmd_position2(pos2),
    .cmd_vmax(prm[3:0]), .cmd_vmax_given(prm[4]), .cmd_vmin(prm[8:5]), .cmd_vmin_given(prm[9]),
    .act_pos, .motion_done, .thermal_pin, .undervolt_pin, .elec_defect_pin, .motion_state,
    .target_pos, .bridges_hiz, .hold_current, .accel_shape, .vmax_eff, .vmin_eff, .id_assign,
    .secure_enable, .sleep_flag, .stop_flag, .step_loss_flag, .tsd_flag, .uv2_flag,
    .eldef_flag, .hw_stop_flag);
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // bounded wait for a state; running out ends the run
  task automatic ws(input logic [3:0] s);
    for (int i = 0; i < 60 && motion_state !== s; i++) @(negedge clk);
    ck(motion_state, s);
    if (motion_state !== s) give_verdict();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    ck(reg_rdata, e);
  endtask
  task automatic md(input logic [15:0] p);
    @(posedge clk);
    act_pos     <= p;
    motion_done <= 1'b1;
    @(posedge clk);
    motion_done <= 1'b0;
  endtask
  task automatic cmd(input int k);
    m_u.send(k, 16'h0000, 16'h0000, 10'h000);
  endtask
  // engine position restarts at zero with the rest of the device
  task automatic wake_up;
    @(posedge clk);
    act_pos <= 16'h0000;
    cmd(11);
    ws(4'h0);
    rd(8'h00, 32'h0000_0000);
    cmd(8);
    ws(4'h1);
  endtask
  task automatic t_reset;
    ck(motion_state, 4'h0);
    rd(8'h10, 32'h0000_0000);
    rd(8'h08, 32'h0000_0400);
    rd(8'h24, 32'h0000_0000);
    cmd(8);
    ws(4'h1);
  endtask
  task automatic t_move;
    m_u.send(0, 16'h0040, 16'h0000, 10'h000);
    ws(4'h2);
    ck(target_pos, 16'h0040);
    md(16'h0040);
    ws(4'h1);
    ck(hold_current, 1'b1);
    @(posedge clk);
    act_pos <= 16'h0041;
    ws(4'h2);
    @(posedge clk);
    clk_en <= 1'b0;
    md(16'h0040);
    cyc(2);
    ck(motion_state, 4'h2);
    @(posedge clk);
    clk_en <= 1'b1;
    md(16'h0040);
    ws(4'h1);
  endtask
  task automatic t_stop;
    m_u.send(0, 16'h0080, 16'h0000, 10'h000);
    ws(4'h2);
    cmd(4);
    ws(4'h4);
    md(16'h0080);
    ws(4'h1);
    ck(stop_flag, 1'b1);
    cyc(1);
    ck(stop_flag, 1'b0);
  endtask
  task automatic t_sleep;
    cmd(6);
    cyc(4);
    ck(motion_state, 4'h1);
    ck(sleep_flag, 1'b1);
    cmd(10);
    cyc(1);
    ck(id_assign, 1'b1);
    ck(sleep_flag, 1'b0);
    ck(motion_state, 4'h1);
    wr(8'h00, 32'h0000_0001);
    cmd(6);
    ws(4'h8);
    cmd(10);
    cyc(1);
    ck(id_assign, 1'b0);
    wake_up();
  endtask
  task automatic t_secure;
    wr(8'h08, 32'h0000_0010);
    cyc(2);
    ck(secure_enable, 1'b1);
    wr(8'h00, 32'h0000_0001);
    cmd(6);
    ws(4'h2);
    ck(target_pos, 16'h0200);
    md(16'h0200);
    ws(4'h8);
    wake_up();
  endtask
  task automatic t_two;
    wr(8'h04, 32'h0000_0023);
    m_u.send(3, 16'h0100, 16'h0180, 10'h015);
    ws(4'h3);
    ck(vmax_eff, 4'h5);
    ck(vmin_eff, 4'h2);
    rd(8'h04, 32'h0000_0023);
    md(16'h0100);
    cyc(1);
    ck(target_pos, 16'h0180);
    ck(accel_shape, 1'b1);
    md(16'h0180);
    ws(4'h1);
    cyc(1);
    ck(accel_shape, 1'b0);
    ck(vmax_eff, 4'h3);
  endtask
  task automatic t_uv;
    @(posedge clk);
    undervolt_pin <= 1'b1;
    cyc(12);
    ck(motion_state, 4'h1);
    ws(4'h9);
    md(16'h0180);
    ws(4'ha);
    @(posedge clk);
    undervolt_pin <= 1'b0;
    ws(4'h1);
    cyc(6);
    cmd(8);
    cyc(1);
    ck(uv2_flag, 1'b0);
  endtask
  task automatic t_therm;
    @(posedge clk);
    thermal_pin <= 1'b1;
    ws(4'h7);
    ck(bridges_hiz, 1'b1);
    @(posedge clk);
    thermal_pin <= 1'b0;
    cyc(8);
    ck(motion_state, 4'h7);
    ck(tsd_flag, 1'b1);
    cmd(8);
    ws(4'h1);
    ck(tsd_flag, 1'b0);
  endtask
  task automatic t_fault;
    m_u.send(0, 16'h0300, 16'h0000, 10'h000);
    ws(4'h2);
    @(posedge clk);
    elec_defect_pin <= 1'b1;
    ws(4'h5);
    @(posedge clk);
    elec_defect_pin <= 1'b0;
    cyc(6);
    ck(step_loss_flag, 1'b1);
    cmd(9);
    cyc(1);
    ck(step_loss_flag, 1'b0);
    ck(hw_stop_flag, 1'b0);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_move();
    t_stop();
    t_sleep();
    t_secure();
    t_two();
    t_uv();
    t_therm();
    t_fault();
    give_verdict();
  end
endmodule
`default_nettype wire
